// ==== verilog/counter_array_pkg.sv ====
// constants for the five-module capture/compare counter array
package counter_array_pkg;

  // ----------------------------------------------------------------
  // structure
  // ----------------------------------------------------------------
  localparam int NUM_MODULES     = 5;
  localparam int WATCHDOG_MODULE = 4;
  localparam int CNT_W           = 16;
  localparam int PWM_W           = 8;
  localparam int STAT_W          = 6;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] COUNT_OFF  = 8'h04;
  localparam logic [7:0] STAT_OFF   = 8'h08;
  localparam logic [7:0] CLEAR_OFF  = 8'h0C;
  localparam logic [7:0] ENABLE_OFF = 8'h10;
  localparam logic [7:0] MODE_BASE  = 8'h20;
  localparam logic [7:0] VALUE_BASE = 8'h40;
  localparam logic [7:0] STRIDE     = 8'h04;

  // ----------------------------------------------------------------
  // counter_array_control fields
  // ----------------------------------------------------------------
  localparam int CTRL_RUN  = 0;
  localparam int CTRL_WDOG = 1;

  // ----------------------------------------------------------------
  // module_mode_control fields
  // ----------------------------------------------------------------
  localparam int MODE_IRQ_EN  = 0;
  localparam int MODE_PWM     = 1;
  localparam int MODE_FLIP    = 2;
  localparam int MODE_EQ_FLAG = 3;
  localparam int MODE_FALL    = 4;
  localparam int MODE_RISE    = 5;
  localparam logic [7:0] MODE_MASK = 8'h3F;

  // ----------------------------------------------------------------
  // status layout and reset values
  // ----------------------------------------------------------------
  localparam int STAT_OVF = 5;
  localparam logic [1:0]  CTRL_RST  = 2'h0;
  localparam logic [7:0]  MODE_RST  = 8'h00;
  localparam logic [15:0] VALUE_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [5:0]  STAT_RST  = 6'h00;

endpackage : counter_array_pkg

// ==== verilog/counter_array_cell.sv ====
// one capture/compare module of the counter array
`timescale 1ns/1ns
module counter_array_cell (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // shared time base
  input  wire logic [15:0] counter,
  input  wire logic        count_step,
  // software side
  input  wire logic [7:0]  mode,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] value,
  output logic             match,
  output logic             event_pulse,
  // pins
  input  wire logic        capture_pin,
  output logic             output_pin
);

  logic [1:0]  sync;
  logic        prev;
  logic [1:0]  next_sync;
  logic        next_prev;
  logic [15:0] next_value;
  logic        next_pin;
  logic        rise;
  logic        fall;
  logic        capture;

  // ----------------------------------------------------------------
  // compare, capture and output logic
  // ----------------------------------------------------------------
  always_comb begin
    next_sync = {sync[0], capture_pin};
    next_prev = sync[1];
    rise = sync[1] & ~prev;
    fall = ~sync[1] & prev;
    capture = (fall & mode[counter_array_pkg::MODE_FALL]) |
              (rise & mode[counter_array_pkg::MODE_RISE]);
    match = count_step & (counter == value);
    event_pulse = (match & mode[counter_array_pkg::MODE_EQ_FLAG]) |
                  capture;
    next_value = value;
    if (wr_en) begin
      next_value = wr_data;
    end
    if (capture) begin
      next_value = counter;
    end
    next_pin = output_pin;
    if (mode[counter_array_pkg::MODE_PWM]) begin
      next_pin = (counter[7:0] >= value[7:0]);
    end else if (match & mode[counter_array_pkg::MODE_FLIP]) begin
      next_pin = ~output_pin;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync       <= 2'h0;
      prev       <= 1'b0;
      value      <= counter_array_pkg::VALUE_RST;
      output_pin <= 1'b0;
    end else begin
      sync       <= next_sync;
      prev       <= next_prev;
      value      <= next_value;
      output_pin <= next_pin;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_flip_on_equal: assert property (@(posedge pclk) disable iff (!presetn)
    match && mode[2] && !mode[1] |=> output_pin != $past(output_pin))
    else $error("output did not invert on equal");
  chk_equal_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    match && mode[3] |-> event_pulse)
    else $error("equal did not raise event");
  chk_capture_value: assert property (@(posedge pclk) disable iff (!presetn)
    capture |=> value == $past(counter))
    else $error("capture did not store counter");
  chk_capture_edge_only: assert property (@(posedge pclk)
    disable iff (!presetn)
    capture |-> (rise && mode[5]) || (fall && mode[4]))
    else $error("capture without enabled edge");
  chk_pwm_level: assert property (@(posedge pclk) disable iff (!presetn)
    mode[1] |=> output_pin == ($past(counter[7:0]) >= $past(value[7:0])))
    else $error("pwm level wrong");
  cov_capture: cover property (@(posedge pclk) disable iff (!presetn)
    capture);
  cov_pwm: cover property (@(posedge pclk) disable iff (!presetn)
    mode[1] && output_pin);

endmodule : counter_array_cell

// ==== verilog/counter_array_modules_watchdog.sv ====
// counter array with five capture/compare modules and a watchdog
// ------------------------------------------------------------------
// Overview of operation
// - five modules, each capture, timer, toggling output or 8-bit pwm
// - only module 4 can be the watchdog, else ordinary module
// - every module owns a mode register selecting its function
// - mode bit 0 lets the module event flag raise the interrupt
// - mode bit 1 selects pulse width modulation
// - mode bit 2 inverts the module output on counter equal
// - mode bit 3 sets the event flag on counter equal
// - bit 4 captures falling edges, bit 5 rising, both for either
// - watchdog compares module 4 value with counter, match gives reset
// - watchdog reset is internal only, never shown on reset pin
// - clearing watchdog enable before match prevents reset; set re-arms
// - one shared counter times all modules, writes affect all
// ------------------------------------------------------------------
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ns
module counter_array_modules_watchdog (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // module pins
  input  wire logic [4:0]  module_capture_pin,
  output logic      [4:0]  module_output_pin,
  // system
  output logic             irq,
  output logic             watchdog_reset
);

  localparam int N = counter_array_pkg::NUM_MODULES;
  localparam int W = counter_array_pkg::WATCHDOG_MODULE;

  logic [1:0]  counter_array_control;
  logic [15:0] counter;
  logic        count_step;
  logic [5:0]  irq_status;
  logic [5:0]  irq_enable;
  logic [7:0]  module_mode_control [N];

  logic [1:0]  next_control;
  logic [15:0] next_counter;
  logic        next_step;
  logic [5:0]  next_status;
  logic [5:0]  next_enable;
  logic [7:0]  next_mode [N];
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_irq;
  logic        next_wd_reset;

  logic        wr;
  logic        mapped;
  logic        count_wr;
  logic        overflow;
  logic [5:0]  irq_gate;
  logic [5:0]  next_gate;
  logic [4:0]  value_wr;
  logic [15:0] value [N];
  logic [4:0]  match;
  logic [4:0]  module_n_event_flag;
  logic [4:0]  pin_out;

  // ----------------------------------------------------------------
  // module instances
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_cell
      counter_array_cell u_cell (
        .pclk        (pclk),
        .presetn     (presetn),
        .counter     (counter),
        .count_step  (count_step),
        .mode        (module_mode_control[g]),
        .wr_en       (value_wr[g]),
        .wr_data     (pwdata[15:0]),
        .value       (value[g]),
        .match       (match[g]),
        .event_pulse (module_n_event_flag[g]),
        .capture_pin (module_capture_pin[g]),
        .output_pin  (pin_out[g])
      );
    end
  endgenerate

  assign module_output_pin = pin_out;

  // ----------------------------------------------------------------
  // apb decode and read mux
  // ----------------------------------------------------------------
  always_comb begin
    wr = psel & penable & pready & pwrite;
    count_wr = wr & (paddr == counter_array_pkg::COUNT_OFF);
    value_wr = 5'h00;
    next_pready = psel & penable & ~pready;
    next_prdata = prdata;
    mapped = 1'b0;
    case (paddr)
      counter_array_pkg::CTRL_OFF: begin
        mapped = 1'b1;
        next_prdata = {30'h0, counter_array_control};
      end
      counter_array_pkg::COUNT_OFF: begin
        mapped = 1'b1;
        next_prdata = {16'h0, counter};
      end
      counter_array_pkg::STAT_OFF: begin
        mapped = 1'b1;
        next_prdata = {26'h0, irq_status};
      end
      counter_array_pkg::CLEAR_OFF: begin
        mapped = 1'b1;
        next_prdata = 32'h0;
      end
      counter_array_pkg::ENABLE_OFF: begin
        mapped = 1'b1;
        next_prdata = {26'h0, irq_enable};
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
    for (int i = 0; i < N; i++) begin
      if (paddr == 8'(counter_array_pkg::MODE_BASE +
                      8'(i) * counter_array_pkg::STRIDE)) begin
        mapped = 1'b1;
        next_prdata = {24'h0, module_mode_control[i]};
      end
      if (paddr == 8'(counter_array_pkg::VALUE_BASE +
                      8'(i) * counter_array_pkg::STRIDE)) begin
        mapped = 1'b1;
        next_prdata = {16'h0, value[i]};
        value_wr[i] = wr;
      end
    end
    if (!next_pready) begin
      next_prdata = prdata;
    end
    next_pslverr = next_pready ? ~mapped : pslverr;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // control, mode registers and shared counter
  // ----------------------------------------------------------------
  always_comb begin
    next_control = counter_array_control;
    next_enable = irq_enable;
    for (int i = 0; i < N; i++) begin
      next_mode[i] = module_mode_control[i];
      if (wr && paddr == 8'(counter_array_pkg::MODE_BASE +
                            8'(i) * counter_array_pkg::STRIDE)) begin
        next_mode[i] = pwdata[7:0] & counter_array_pkg::MODE_MASK;
      end
    end
    if (wr && paddr == counter_array_pkg::CTRL_OFF) begin
      next_control = pwdata[1:0];
    end
    if (wr && paddr == counter_array_pkg::ENABLE_OFF) begin
      next_enable = pwdata[5:0];
    end
    next_counter = counter;
    if (counter_array_control[counter_array_pkg::CTRL_RUN]) begin
      next_counter = 16'(counter + 16'h0001);
    end
    if (count_wr) begin
      next_counter = pwdata[15:0];
    end
    next_step = counter_array_control[counter_array_pkg::CTRL_RUN] |
                count_wr;
    overflow = counter_array_control[counter_array_pkg::CTRL_RUN] &
               (counter == 16'hFFFF) & ~count_wr;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_array_control <= counter_array_pkg::CTRL_RST;
      irq_enable            <= counter_array_pkg::STAT_RST;
      counter               <= counter_array_pkg::COUNT_RST;
      count_step            <= 1'b0;
      for (int i = 0; i < N; i++) begin
        module_mode_control[i] <= counter_array_pkg::MODE_RST;
      end
    end else begin
      counter_array_control <= next_control;
      irq_enable            <= next_enable;
      counter               <= next_counter;
      count_step            <= next_step;
      for (int i = 0; i < N; i++) begin
        module_mode_control[i] <= next_mode[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // event flags, interrupt and watchdog
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < N; i++) begin
      irq_gate[i] = module_mode_control[i][counter_array_pkg::MODE_IRQ_EN];
      next_gate[i] = next_mode[i][counter_array_pkg::MODE_IRQ_EN];
    end
    irq_gate[counter_array_pkg::STAT_OVF] = 1'b1;
    next_gate[counter_array_pkg::STAT_OVF] = 1'b1;
    next_status = irq_status;
    if (wr && paddr == counter_array_pkg::CLEAR_OFF) begin
      next_status = irq_status & ~pwdata[5:0];
    end
    next_status = next_status | {overflow, module_n_event_flag};
    next_irq = |(next_status & next_enable & next_gate);
    next_wd_reset = counter_array_control[counter_array_pkg::CTRL_WDOG] &
                    match[W];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status     <= counter_array_pkg::STAT_RST;
      irq            <= 1'b0;
      watchdog_reset <= 1'b0;
    end else begin
      irq_status     <= next_status;
      irq            <= next_irq;
      watchdog_reset <= next_wd_reset;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_watchdog_fires: assert property (@(posedge pclk) disable iff (!presetn)
    counter_array_control[1] && match[4] |=> watchdog_reset)
    else $error("watchdog match gave no reset");
  chk_watchdog_disabled: assert property (@(posedge pclk)
    disable iff (!presetn)
    !counter_array_control[1] |=> !watchdog_reset)
    else $error("reset while watchdog disabled");
  chk_watchdog_only_mod4: assert property (@(posedge pclk)
    disable iff (!presetn)
    watchdog_reset |-> $past(match[4]))
    else $error("reset without module 4 match");
  chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    (|(irq_status & irq_enable & irq_gate)) [*2] |-> irq)
    else $error("enabled flag gave no interrupt");
  chk_irq_gated: assert property (@(posedge pclk) disable iff (!presetn)
    irq |-> |(irq_status & irq_enable & irq_gate))
    else $error("interrupt without enabled flag");
  chk_counter_shared: assert property (@(posedge pclk)
    disable iff (!presetn)
    counter_array_control[0] && !count_wr |=>
      counter == 16'($past(counter) + 16'h0001))
    else $error("shared counter did not advance");
  chk_set_beats_clear: assert property (@(posedge pclk)
    disable iff (!presetn)
    module_n_event_flag[0] |=> irq_status[0])
    else $error("event flag lost");
  cov_watchdog: cover property (@(posedge pclk) disable iff (!presetn)
    watchdog_reset);
  cov_irq: cover property (@(posedge pclk) disable iff (!presetn)
    irq ##1 !irq);
  cov_overflow: cover property (@(posedge pclk) disable iff (!presetn)
    overflow);

endmodule : counter_array_modules_watchdog

// ==== testbench/capture_source.sv ====
// capture pin source standing in for the external signal side
`timescale 1ns/1ns
module capture_source (
  // clock
  input  wire logic       pclk,
  // capture pins
  output logic      [4:0] pins
);
  // pins start low so no false edge follows reset
  initial pins = 5'h00;

  // levels change only just after a rising edge
  task automatic set_level(input logic [4:0] v);
    @(posedge pclk);
    pins <= v;
  endtask : set_level
endmodule : capture_source

// ==== testbench/testbench.sv ====
// self-checking bench for the counter array with watchdog
`timescale 1ns/1ns
module testbench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  cap_pins;
  logic [4:0]  out_pins;
  logic        irq;
  logic        watchdog_reset;
  logic [32:0] exp_q[$];
  logic [32:0] note;
  logic [15:0] rnd;
  int          mismatches;
  int          check_count;
  int          wd_count;
  int          n0;

  counter_array_modules_watchdog uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .module_capture_pin(cap_pins),
    .module_output_pin(out_pins), .irq(irq),
    .watchdog_reset(watchdog_reset)
  );
  capture_source src (.pclk(pclk), .pins(cap_pins));

  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  function automatic logic [7:0] maddr(input int i);
    return 8'(counter_array_pkg::MODE_BASE + 4 * i);
  endfunction : maddr

  function automatic logic [7:0] vaddr(input int i);
    return 8'(counter_array_pkg::VALUE_BASE + 4 * i);
  endfunction : vaddr

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      mismatches++;
      complete_run();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic e,
                    input logic [31:0] d);
    exp_q.push_back({e, d});
    apb(a, 1'b0, 32'h0000_0000);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // sel 5 waits on the watchdog request, else on an output pin
  task automatic wait_for(input int sel, input logic lvl);
    int n;
    for (n = 0; n < 600; n++) begin
      @(posedge pclk);
      if (sel == 5 && watchdog_reset === lvl) return;
      if (sel < 5 && out_pins[sel] === lvl) return;
    end
    mismatches++;
    complete_run();
  endtask : wait_for

  // ------------------------------------------------------------
  // read monitor and watchdog pulse counter
  // ------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      note = exp_q.pop_front();
      check({31'h0, pslverr}, {31'h0, note[32]});
      if (!note[32]) check(prdata, note[31:0]);
    end
    if (watchdog_reset === 1'b1) wd_count++;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    mismatches = 0;
    check_count = 0;
    wd_count = 0;
    rnd = 16'h259D;
    tick(20);
    presetn <= 1'b1;
    // reset values and unmapped place
    for (int i = 0; i < 5; i++) begin
      rd(maddr(i), 1'b0, 32'h0);
      rd(vaddr(i), 1'b0, 32'h0);
    end
    rd(counter_array_pkg::STAT_OFF, 1'b0, 32'h0);
    rd(counter_array_pkg::CLEAR_OFF, 1'b0, 32'h0);
    rd(8'h80, 1'b1, 32'h0);
    // random mode and value words
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      wr(maddr(i), {24'h0, rnd[7:0]});
      rd(maddr(i), 1'b0, {24'h0, rnd[7:0] & 8'h3F});
      wr(vaddr(i), {16'h0, rnd});
      rd(vaddr(i), 1'b0, {16'h0, rnd});
      wr(maddr(i), 32'h0);
    end
    // equal flag, flip, interrupt
    wr(maddr(0), 32'h0D);
    wr(vaddr(0), 32'h10);
    wr(maddr(1), 32'h04);
    wr(vaddr(1), 32'h14);
    wr(counter_array_pkg::COUNT_OFF, 32'h0C);
    wr(counter_array_pkg::ENABLE_OFF, 32'h01);
    wr(counter_array_pkg::CTRL_OFF, 32'h01);
    wait_for(1, 1'b1);
    wr(counter_array_pkg::CTRL_OFF, 32'h00);
    check({27'h0, out_pins}, 32'h03);
    rd(counter_array_pkg::STAT_OFF, 1'b0, 32'h01);
    check({31'h0, irq}, 32'h1);
    wr(counter_array_pkg::ENABLE_OFF, 32'h00);
    tick(2);
    check({31'h0, irq}, 32'h0);
    wr(counter_array_pkg::ENABLE_OFF, 32'h01);
    wr(counter_array_pkg::CLEAR_OFF, 32'h01);
    tick(2);
    check({31'h0, irq}, 32'h0);
    rd(counter_array_pkg::STAT_OFF, 1'b0, 32'h0);
    // counter reload moves both flip modules 0 and 1
    wr(counter_array_pkg::COUNT_OFF, 32'h0E);
    wr(counter_array_pkg::CTRL_OFF, 32'h01);
    wait_for(1, 1'b0);
    wr(counter_array_pkg::CTRL_OFF, 32'h00);
    check({27'h0, out_pins}, 32'h00);
    // pulse width modulation
    wr(maddr(0), 32'h02);
    wr(vaddr(0), 32'h80);
    wr(counter_array_pkg::COUNT_OFF, 32'h90);
    tick(2);
    check({31'h0, out_pins[0]}, 32'h1);
    wr(counter_array_pkg::COUNT_OFF, 32'h70);
    tick(2);
    check({31'h0, out_pins[0]}, 32'h0);
    wr(maddr(0), 32'h00);
    // capture on falling, rising and both edges
    wr(counter_array_pkg::CLEAR_OFF, 32'h3F);
    wr(maddr(2), 32'h10);
    wr(maddr(3), 32'h20);
    wr(maddr(4), 32'h30);
    wr(counter_array_pkg::COUNT_OFF, 32'h1234);
    src.set_level(5'h1C);
    tick(6);
    wr(counter_array_pkg::COUNT_OFF, 32'h5678);
    src.set_level(5'h00);
    tick(6);
    rd(vaddr(2), 1'b0, 32'h5678);
    rd(vaddr(3), 1'b0, 32'h1234);
    rd(vaddr(4), 1'b0, 32'h5678);
    rd(counter_array_pkg::STAT_OFF, 1'b0, 32'h1C);
    for (int i = 2; i < 5; i++) wr(maddr(i), 32'h0);
    // watchdog held off, disabled, then re-armed
    wr(vaddr(4), 32'h40);
    wr(counter_array_pkg::COUNT_OFF, 32'h0);
    n0 = wd_count;
    wr(counter_array_pkg::CTRL_OFF, 32'h03);
    for (int k = 1; k <= 8; k++) begin
      wr(vaddr(4), 32'h40 + 32'h20 * k);
    end
    check(32'(wd_count - n0), 32'h0);
    wr(counter_array_pkg::CTRL_OFF, 32'h01);
    tick(400);
    check(32'(wd_count - n0), 32'h0);
    wr(counter_array_pkg::COUNT_OFF, 32'h100);
    wr(counter_array_pkg::CTRL_OFF, 32'h03);
    wait_for(5, 1'b1);
    @(posedge pclk);
    check(32'(wd_count - n0), 32'h1);
    check({31'h0, watchdog_reset}, 32'h0);
    wr(counter_array_pkg::CTRL_OFF, 32'h00);
    tick(4);
    // counter wrap sets the overflow flag
    wr(counter_array_pkg::CLEAR_OFF, 32'h3F);
    wr(counter_array_pkg::COUNT_OFF, 32'hFFF0);
    wr(counter_array_pkg::CTRL_OFF, 32'h01);
    tick(20);
    rd(counter_array_pkg::STAT_OFF, 1'b0, 32'h20);
    wr(counter_array_pkg::CTRL_OFF, 32'h00);
    check(32'(exp_q.size()), 32'h0);
    complete_run();
  end
endmodule : testbench
